// File: pfs_core_model.sv
// Purpose: behavioural core that runs self-access sequences over APB
// Assumes: one transfer per instruction, an idle cycle between transfers
// Notes: the core halts while coreStall is high only inside waitResume, and for at most 100 stalled cycles
`timescale 1ns/100ps
module pfs_core_model (
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic coreStall
);
   import pfs_pkg::*;
   logic [31:0] lastRead;
   logic lastErr;
   //////////////////////////////////////////////////////////////////////////////
   // bus idle from time zero so nothing is taken during reset
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // one transfer; request held until pready is seen high at an edge
   task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      lastRead = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // up to four no-op slots until the stall starts, then halt while stalled; bounded so a stuck stall ends
   task automatic waitResume(output int lead, output int held);
      lead = 0;
      held = 0;
      @(posedge clk);
      while (coreStall !== 1'b1 && lead < 4) begin
         lead++;
         @(posedge clk);
      end
      while (coreStall === 1'b1 && held < 100) begin
         held++;
         @(posedge clk);
      end
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // address pair first, since every operation uses it
   task automatic setAddr(input logic [14:0] a);
      busXfer(1'b1, OFS_ADDR_LO, {24'h0, a[7:0]});
      busXfer(1'b1, OFS_ADDR_HI, {25'h0, a[14:8]});
   endtask
   task automatic readWord(input logic [14:0] a, output logic [13:0] w,
                           output int lead, output int held);
      setAddr(a);
      busXfer(1'b1, OFS_CTRL, 32'h80);
      busXfer(1'b1, OFS_CTRL, 32'h81);
      waitResume(lead, held);
      busXfer(1'b0, OFS_DATA_LO, 32'h0);
      w[7:0] = lastRead[7:0];
      busXfer(1'b0, OFS_DATA_HI, 32'h0);
      w[13:8] = lastRead[5:0];
   endtask
   // keys back to back; any other write between them would disarm
   task automatic unlockWrite(input logic [7:0] c, output int lead, output int held);
      busXfer(1'b1, OFS_CTRL, {24'h0, c});
      busXfer(1'b1, OFS_UNLOCK, {24'h0, UNLOCK_KEY_1});
      busXfer(1'b1, OFS_UNLOCK, {24'h0, UNLOCK_KEY_2});
      busXfer(1'b1, OFS_CTRL, {24'h0, c | 8'h02});
      waitResume(lead, held);
   endtask
   task automatic eraseRow(input logic [14:0] a, output int lead, output int held);
      setAddr(a);
      unlockWrite(8'h94, lead, held);
   endtask
   task automatic loadWord(input logic [14:0] a, input logic [13:0] d, input logic last,
                           output int lead, output int held);
      setAddr(a);
      busXfer(1'b1, OFS_DATA_LO, {24'h0, d[7:0]});
      busXfer(1'b1, OFS_DATA_HI, {26'h0, d[13:8]});
      unlockWrite(last ? 8'h84 : 8'hA4, lead, held);
   endtask
endmodule

// File: pfs_flash_ctrl.sv
// Purpose: program flash self-access controller (read, row erase, block write)
// Assumes: core stalls while coreStall is high; one APB access per instruction
// Notes: flash array is held here; erase and program take BUSY_CYCLES clocks
// How it works
// - flash read in second cycle, stalls core
// - read word lands in data pair next
// - data pair holds until read or write
// - reads ignore the code protect setting
// - erase only ever clears whole rows
// - hardware clears erase select when erase ends
// - two set-up cycles before the stall
// - core stalls 2 ms during row erase
// - core resumes after the stall ends
// - programming never erases, only clears bits
// - one program writes one aligned latch block
// - latches return to 3FFF after programming
// - latch-only write loads latch, no stall
// - final write loads latch and programs block
// - whole latch block programmed every time
// - stall only for the final programming word
// - write bit refused without write enable
// - end clears write bit, sets done flag
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module pfs_flash_ctrl #(
   parameter int FLASH_AW = pfs_pkg::FLASH_AW_DEF,
   parameter int BUSY_CYCLES = pfs_pkg::BUSY_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic codeProtectSetting,
   output logic coreStall
);
   import pfs_pkg::*;

   localparam int CNT_W = $clog2(BUSY_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BUSY_CYCLES - 1);

   // the address pair is 15 bits wide and one block needs LATCH_AW of them
   if (BUSY_CYCLES < 1 || FLASH_AW < LATCH_AW || FLASH_AW > 15) begin : g_param_chk
      $error("pfs_flash_ctrl: unsupported parameter values");
   end

   typedef enum logic [2:0] {ST_IDLE, ST_RD_WAIT, ST_RD_DO, ST_SETUP1, ST_SETUP2, ST_BUSY}
      pfs_state_e;

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0] addrLo_r, addrLo_nxt;
   logic [ADDR_HI_W-1:0] addrHi_r, addrHi_nxt;
   logic [7:0] dataLo_r, dataLo_nxt;
   logic [5:0] dataHi_r, dataHi_nxt;
   pfs_ctrl_s ctrl_r, ctrl_nxt;
   pfs_unlock_e unlock_r, unlock_nxt;
   logic done_r, done_nxt;
   pfs_state_e state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic eraseOp_r, eraseOp_nxt;
   logic [2:0] cpSync_r;
   logic cpLevel_r, cpLevel_nxt;
   logic [CNT_W-1:0] stallLen_r, stallLen_nxt;
   logic latchWe, progGo, eraseGo;
   logic [WORD_W-1:0] flashMem [2**FLASH_AW];
   logic [WORD_W-1:0] latch [LATCH_COUNT];

   wire logic apbWr = psel && penable && pwrite;
   wire logic [14:0] fullAddr = {addrHi_r, addrLo_r};
   wire logic [FLASH_AW-1:0] wordIdx = fullAddr[FLASH_AW-1:0];
   wire logic [LATCH_AW-1:0] latchIdx = addrLo_r[LATCH_AW-1:0];
   wire logic [WORD_W-1:0] rdWord = flashMem[wordIdx];
   wire logic [WORD_W-1:0] dataWord = {dataHi_r, dataLo_r};

   // word index of slot i inside the block that holds the current address
   function automatic logic [FLASH_AW-1:0] blockIdx(input logic [FLASH_AW-1:0] a,
                                                    input int i);
      blockIdx = {a[FLASH_AW-1:LATCH_AW], LATCH_AW'(i)};
   endfunction

   // a new level counts only once the last two stages agree, so a glitch is dropped
   always_comb begin
      cpLevel_nxt = cpLevel_r;
      if (cpSync_r[2] == cpSync_r[1]) begin
         cpLevel_nxt = cpSync_r[2];
      end
   end

   // code protect comes from fuse logic outside this clock; three stages
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cpSync_r <= 3'h0;
         cpLevel_r <= 1'b0;
      end else begin
         cpSync_r <= {cpSync_r[1:0], codeProtectSetting};
         cpLevel_r <= cpLevel_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes and sequencer; hardware events are applied last so they win
   always_comb begin
      addrLo_nxt = addrLo_r;
      addrHi_nxt = addrHi_r;
      dataLo_nxt = dataLo_r;
      dataHi_nxt = dataHi_r;
      ctrl_nxt = ctrl_r;
      unlock_nxt = unlock_r;
      done_nxt = done_r;
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      eraseOp_nxt = eraseOp_r;
      latchWe = 1'b0;
      progGo = 1'b0;
      eraseGo = 1'b0;
      stallLen_nxt = coreStall ? stallLen_r + CNT_W'(1) : '0; // length of the running stall
      if (apbWr) begin
         // any other write between key and write bit breaks the sequence
         unlock_nxt = UNL_NONE;
         unique case (paddr)
            OFS_ADDR_LO: addrLo_nxt = pwdata[7:0];
            OFS_ADDR_HI: addrHi_nxt = pwdata[ADDR_HI_W-1:0];
            OFS_DATA_LO: dataLo_nxt = pwdata[7:0];
            OFS_DATA_HI: dataHi_nxt = pwdata[5:0];
            OFS_UNLOCK: begin
               if (pwdata[7:0] == UNLOCK_KEY_1) begin
                  unlock_nxt = UNL_KEY1;
               end else if (pwdata[7:0] == UNLOCK_KEY_2 && unlock_r == UNL_KEY1) begin
                  unlock_nxt = UNL_ARMED;
               end
            end
            OFS_STATUS: begin
               if (!pwdata[STAT_DONE_BIT]) begin
                  done_nxt = 1'b0;
               end
            end
            OFS_CTRL: begin
               ctrl_nxt.programMemSel = pwdata[7];
               ctrl_nxt.configSpaceSel = pwdata[6];
               ctrl_nxt.latchOnlySel = pwdata[5];
               ctrl_nxt.writeEnableBit = pwdata[2];
               // erase select is owned by hardware while an operation runs
               if (state_r == ST_IDLE) begin
                  ctrl_nxt.rowEraseSel = pwdata[4];
               end
               // the read ignores code protect entirely
               if (state_r == ST_IDLE && pwdata[0] && pwdata[7] && !pwdata[6]) begin
                  ctrl_nxt.readBit = 1'b1;
                  state_nxt = ST_RD_WAIT;
               end else if (state_r == ST_IDLE && pwdata[1] && ctrl_r.writeEnableBit
                            && unlock_r == UNL_ARMED && pwdata[7] && !pwdata[6]) begin
                  // accepted only with write enable already set and the key pair
                  if (pwdata[4]) begin
                     ctrl_nxt.writeBit = 1'b1;
                     eraseOp_nxt = 1'b1;
                     state_nxt = ST_SETUP1;
                  end else if (pwdata[5]) begin
                     latchWe = 1'b1;
                     done_nxt = 1'b1;
                  end else begin
                     latchWe = 1'b1;
                     ctrl_nxt.writeBit = 1'b1;
                     eraseOp_nxt = 1'b0;
                     state_nxt = ST_SETUP1;
                  end
               end
            end
            default: ;
         endcase
      end
      unique case (state_r)
         ST_IDLE: ;
         ST_RD_WAIT: state_nxt = ST_RD_DO;
         ST_RD_DO: begin
            // word appears in the pair the cycle after the stalled read cycle
            dataLo_nxt = rdWord[7:0];
            dataHi_nxt = rdWord[13:8];
            ctrl_nxt.readBit = 1'b0;
            state_nxt = ST_IDLE;
         end
         ST_SETUP1: state_nxt = ST_SETUP2;
         ST_SETUP2: begin
            cnt_nxt = '0;
            state_nxt = ST_BUSY;
         end
         ST_BUSY: begin
            cnt_nxt = cnt_r + CNT_W'(1);
            if (cnt_r == CNT_LAST) begin
               eraseGo = eraseOp_r;
               progGo = !eraseOp_r;
               ctrl_nxt.writeBit = 1'b0;
               ctrl_nxt.rowEraseSel = 1'b0;
               done_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         addrLo_r <= 8'h00;
         addrHi_r <= '0;
         dataLo_r <= 8'h00;
         dataHi_r <= 6'h00;
         ctrl_r <= CTRL_RESET;
         unlock_r <= UNL_NONE;
         done_r <= 1'b0;
         state_r <= ST_IDLE;
         cnt_r <= '0;
         eraseOp_r <= 1'b0;
         stallLen_r <= '0;
      end else begin
         addrLo_r <= addrLo_nxt;
         addrHi_r <= addrHi_nxt;
         dataLo_r <= dataLo_nxt;
         dataHi_r <= dataHi_nxt;
         ctrl_r <= ctrl_nxt;
         unlock_r <= unlock_nxt;
         done_r <= done_nxt;
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         eraseOp_r <= eraseOp_nxt;
         stallLen_r <= stallLen_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write latches: loaded one at a time, emptied back to all ones after a program
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < LATCH_COUNT; i++) begin
            latch[i] <= LATCH_RESET;
         end
      end else if (progGo) begin
         for (int i = 0; i < LATCH_COUNT; i++) begin
            latch[i] <= LATCH_RESET;
         end
      end else if (latchWe) begin
         latch[latchIdx] <= dataWord;
      end
   end

   // flash array; programming can only clear bits, so nothing is erased by it
   // and untouched latches (all ones) leave their words as they were
   always_ff @(posedge clk) begin
      if (eraseGo) begin
         for (int i = 0; i < LATCH_COUNT; i++) begin
            flashMem[blockIdx(wordIdx, i)] <= ERASED_WORD;
         end
      end else if (progGo) begin
         for (int i = 0; i < LATCH_COUNT; i++) begin
            // whole aligned block, never past its boundary
            flashMem[blockIdx(wordIdx, i)] <= flashMem[blockIdx(wordIdx, i)] & latch[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core stall: the read cycle, and the whole erase or program time
   assign coreStall = state_r inside {ST_RD_DO, ST_BUSY};

   // apb answer: zero wait states, error on unmapped offsets
   assign pready = 1'b1;
   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      unique case (paddr)
         OFS_ADDR_LO: prdata[7:0] = addrLo_r;
         OFS_ADDR_HI: prdata[ADDR_HI_W-1:0] = addrHi_r;
         OFS_DATA_LO: prdata[7:0] = dataLo_r;
         OFS_DATA_HI: prdata[5:0] = dataHi_r;
         OFS_CTRL: prdata[7:0] = ctrl_r;
         OFS_UNLOCK: prdata = 32'h0000_0000; // key register reads as zero
         OFS_STATUS: begin
            prdata[STAT_DONE_BIT] = done_r;
            prdata[STAT_BUSY_BIT] = (state_r != ST_IDLE);
            prdata[STAT_CP_BIT] = cpLevel_r;
         end
         default: pslverr = psel && penable;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   wire logic ctrlWrite = apbWr && paddr == OFS_CTRL;

   property p_rd_stall;
      @(posedge clk) disable iff (!resetn)
      (ctrlWrite && state_r == ST_IDLE && pwdata[0] && pwdata[7] && !pwdata[6])
         |=> !coreStall ##1 coreStall ##1 !coreStall;
   endproperty
   a_rd_stall: assert property (p_rd_stall) else $error("read stall timing wrong");

   property p_rd_data;
      logic [WORD_W-1:0] w;
      @(posedge clk) disable iff (!resetn)
      (state_r == ST_RD_DO, w = rdWord) |=> {dataHi_r, dataLo_r} == w && !ctrl_r.readBit;
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read word not in data pair");

   property p_wr_needs_enable;
      @(posedge clk) disable iff (!resetn)
      $rose(ctrl_r.writeBit) |-> $past(ctrl_r.writeEnableBit);
   endproperty
   a_wr_needs_enable: assert property (p_wr_needs_enable)
      else $error("write without enable");

   property p_wr_needs_unlock;
      @(posedge clk) disable iff (!resetn)
      ($rose(ctrl_r.writeBit) || latchWe)
         |-> $past(unlock_r == UNL_ARMED) || unlock_r == UNL_ARMED;
   endproperty
   a_wr_needs_unlock: assert property (p_wr_needs_unlock)
      else $error("write without unlock");

   property p_setup;
      @(posedge clk) disable iff (!resetn)
      $rose(ctrl_r.writeBit) |-> !coreStall [*2] ##1 coreStall;
   endproperty
   a_setup: assert property (p_setup) else $error("set-up cycles wrong");

   property p_erase_end;
      @(posedge clk) disable iff (!resetn)
      eraseGo |=> !ctrl_r.rowEraseSel && !ctrl_r.writeBit && done_r && !coreStall;
   endproperty
   a_erase_end: assert property (p_erase_end) else $error("erase end not flagged");

   property p_prog_end;
      @(posedge clk) disable iff (!resetn)
      progGo |=> latch[0] == LATCH_RESET && latch[LATCH_COUNT-1] == LATCH_RESET && done_r;
   endproperty
   a_prog_end: assert property (p_prog_end) else $error("latches not reset");

   property p_latch_only;
      @(posedge clk) disable iff (!resetn)
      (latchWe && state_nxt == ST_IDLE) |=> !coreStall [*3];
   endproperty
   a_latch_only: assert property (p_latch_only) else $error("latch load stalled");

   property p_stall_len;
      @(posedge clk) disable iff (!resetn)
      ($fell(coreStall) && $past(state_r == ST_BUSY)) |-> stallLen_r == CNT_W'(BUSY_CYCLES);
   endproperty
   a_stall_len: assert property (p_stall_len) else $error("stall length wrong");

   c_read: cover property (@(posedge clk) disable iff (!resetn) state_r == ST_RD_DO);
   c_erase: cover property (@(posedge clk) disable iff (!resetn) eraseGo);
   c_program: cover property (@(posedge clk) disable iff (!resetn) progGo);
   c_latch: cover property (@(posedge clk) disable iff (!resetn) latchWe && ctrl_r.latchOnlySel);
endmodule

// File: pfs_pkg.sv
// Purpose: shared constants and types of the program flash self-access block
// Assumes: 32-bit APB, one word per register, 14-bit flash words
// Notes: the ctrl bit layout is carried as a packed struct
package pfs_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_ADDR_LO = 8'h00;
   localparam logic [7:0] OFS_ADDR_HI = 8'h04;
   localparam logic [7:0] OFS_DATA_LO = 8'h08;
   localparam logic [7:0] OFS_DATA_HI = 8'h0C;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_UNLOCK = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   // status bit positions
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_CP_BIT = 2;
   // unlock key values, in the order they must arrive
   localparam logic [7:0] UNLOCK_KEY_1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY_2 = 8'hAA;
   // flash word and latch geometry
   localparam int WORD_W = 14;
   localparam logic [WORD_W-1:0] LATCH_RESET = 14'h3FFF;
   localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3FFF;
   localparam int LATCH_COUNT = 32;
   localparam int LATCH_AW = 5;
   localparam int ADDR_HI_W = 7;
   localparam int FLASH_AW_DEF = 12;
   // erase / program time
   localparam int CLK_MHZ = 250;
   localparam int BUSY_TIME_US = 2000;
   localparam int BUSY_CYCLES_DEF = BUSY_TIME_US * CLK_MHZ;
   // core-side set-up cycles after the write bit
   localparam int SETUP_CYCLES = 2;

   typedef struct packed {
      logic programMemSel;
      logic configSpaceSel;
      logic latchOnlySel;
      logic rowEraseSel;
      logic rsvd;
      logic writeEnableBit;
      logic writeBit;
      logic readBit;
   } pfs_ctrl_s;

   localparam pfs_ctrl_s CTRL_RESET = '0;

   typedef enum logic [1:0] {UNL_NONE, UNL_KEY1, UNL_ARMED} pfs_unlock_e;
endpackage

// File: testbench.sv
// Purpose: self-checking bench for the flash self-access block
// Assumes: short busy time, code protect held set throughout
// Notes: every sequence runs through the core model
`timescale 1ns/100ps
module testbench;
   import pfs_pkg::*;
   localparam int BUSY = 8;
   localparam logic [14:0] ADDR_TAB [7] = '{15'h0020, 15'h0021, 15'h0022, 15'h0023,
                                           15'h0040, 15'h0041, 15'h005F};
   localparam logic [31:0] EXP_TAB [7] = '{32'h0034, 32'h2ABC, 32'h0F0F, 32'h3FFF,
                                          32'h3FFF, 32'h1555, 32'h3FFF};
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, coreStall, cpSet;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   int errorCnt = 0;
   int checksDone = 0;
   int cycles = 0;
   //////////////////////////////////////////////////////////////////////////////
   pfs_flash_ctrl #(.FLASH_AW(12), .BUSY_CYCLES(BUSY)) u_dut (.clk(clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .codeProtectSetting(cpSet),
      .coreStall(coreStall));
   pfs_core_model u_core (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .coreStall(coreStall));
   // clock, and a ceiling well above the few hundred cycles needed
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errorCnt++;
         testDone();
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
      u_core.busXfer(1'b0, a, 32'h0);
      check(what, exp, u_core.lastRead);
   endtask
   // a broken start must neither stall the core nor raise the done flag
   task automatic tryBad(input logic [7:0] pre, input logic [7:0] k1, input logic [7:0] k2);
      int lead, held;
      u_core.busXfer(1'b1, OFS_CTRL, {24'h0, pre});
      u_core.busXfer(1'b1, OFS_UNLOCK, {24'h0, k1});
      u_core.busXfer(1'b1, OFS_UNLOCK, {24'h0, k2});
      u_core.busXfer(1'b1, OFS_CTRL, 32'h86);
      u_core.waitResume(lead, held);
      check("refused stall", 32'h0, held);
      rdChk(OFS_STATUS, 32'h4, "refused done");
   endtask
   task automatic testDone();
      $display("checks %0d mismatches %0d", checksDone, errorCnt);
      if (errorCnt == 0 && checksDone > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [13:0] w;
      int lead, held;
      cpSet = 1'b1;
      resetn = 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      // reset state, key register reads zero, unmapped place errors
      rdChk(OFS_CTRL, 32'h0, "ctrl reset");
      rdChk(OFS_UNLOCK, 32'h0, "unlock read");
      u_core.busXfer(1'b0, 8'h1C, 32'h0);
      check("unmapped error", 32'h1, {31'h0, u_core.lastErr});
      rdChk(OFS_STATUS, 32'h4, "status reset");
      $display("test reset done");
      // erase from mid-row address clears the whole row
      u_core.eraseRow(15'h0025, lead, held);
      check("erase lead", SETUP_CYCLES, lead);
      check("erase stall", BUSY, held);
      rdChk(OFS_CTRL, 32'h84, "erase sel cleared");
      rdChk(OFS_STATUS, 32'h5, "erase done");
      u_core.busXfer(1'b1, OFS_STATUS, 32'h0);
      u_core.eraseRow(15'h0045, lead, held);
      $display("test erase done");
      u_core.readWord(15'h003F, w, lead, held);
      check("read word", 32'h3FFF, {18'h0, w});
      check("read lead", 32'h1, lead);
      check("read stall", 32'h1, held);
      $display("test read done");
      // partial block, then a lone word in a fresh block, then over old data
      u_core.loadWord(15'h0020, 14'h1234, 1'b0, lead, held);
      check("latch stall", 32'h0, held);
      u_core.loadWord(15'h0021, 14'h2ABC, 1'b0, lead, held);
      u_core.loadWord(15'h0022, 14'h0F0F, 1'b1, lead, held);
      check("program lead", SETUP_CYCLES, lead);
      check("program stall", BUSY, held);
      rdChk(OFS_CTRL, 32'h84, "program wr cleared");
      u_core.loadWord(15'h0041, 14'h1555, 1'b1, lead, held);
      u_core.loadWord(15'h0020, 14'h00FF, 1'b1, lead, held);
      for (int i = 0; i < 7; i++) begin
         u_core.readWord(ADDR_TAB[i], w, lead, held);
         check("flash word", EXP_TAB[i], {18'h0, w});
      end
      $display("test program done");
      // data pair keeps the last read until software overwrites a half
      u_core.busXfer(1'b1, OFS_DATA_LO, 32'h5A);
      rdChk(OFS_DATA_LO, 32'h5A, "data lo written");
      rdChk(OFS_DATA_HI, 32'h3F, "data hi held");
      // a read with configuration space selected is not taken
      u_core.busXfer(1'b1, OFS_CTRL, 32'hC1);
      u_core.waitResume(lead, held);
      check("cfg read stall", 32'h0, held);
      rdChk(OFS_DATA_LO, 32'h5A, "data lo kept");
      u_core.busXfer(1'b1, OFS_STATUS, 32'h0);
      tryBad(8'h80, UNLOCK_KEY_1, UNLOCK_KEY_2);
      tryBad(8'h84, UNLOCK_KEY_2, UNLOCK_KEY_1);
      $display("test refusal done");
      testDone();
   end
endmodule
